/* src/spmu_uart.sv */
`timescale 1ns/1ps
`default_nettype none
module spmu_uart
  import spmu_pkg::*;
#(
  parameter int unsigned ADDR_W = 5
) (
  // Clock, reset and enable
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic              ce_in,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Baud sources
  input  wire logic              timer1_ovf_in,
  input  wire logic              timer2_ovf_in,
  // Serial pins
  input  wire logic              rxd_in,
  output logic                   rxd_out,
  output logic                   rxd_oe_out,
  output logic                   txd_out,
  // Interrupt request
  output logic                   serial_irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic           wait_req;
    logic [7:0]     rdata;
    spmu_mode_e     mode;
    logic           filter_en;
    logic           rx_en;
    logic           tb8;
    logic           rb8;
    logic           ti;
    logic           ri;
    logic           fe;
    logic [7:0]     node_addr;
    logic [7:0]     node_mask;
    logic           baud_double;
    logic           err_sel;
    logic           tx_src;
    logic           rx_src;
    logic [7:0]     rx_buf;
    spmu_rx_state_e rx_st;
    logic [3:0]     rx_sub;
    logic [3:0]     rx_bitn;
    logic [8:0]     rx_shift;
    logic           rx_prev;
    logic           m0_act;
    logic           m0_rx;
    logic           m0_fell;
    logic           m0_clk;
    logic [3:0]     m0_cnt;
    logic [7:0]     m0_shift;
    logic           tx_start;
    logic [7:0]     tx_data;
    logic           tx_ninth;
    logic           txd;
    logic           rxd_o;
    logic           rxd_oe;
    logic           irq;
  } spmu_top_s;

  localparam spmu_top_s TOP_RST = '{
    wait_req:    1'b1,
    mode:        spmu_mode_e'(SPMU_CTRL_RST[SPMU_CTRL_MODE_HI:SPMU_CTRL_MODE_LO]),
    filter_en:   SPMU_CTRL_RST[SPMU_CTRL_FILTER],
    rx_en:       SPMU_CTRL_RST[SPMU_CTRL_RX_EN],
    tb8:         SPMU_CTRL_RST[SPMU_CTRL_TB8],
    node_addr:   SPMU_ADDR_RST,
    node_mask:   SPMU_MASK_RST,
    baud_double: SPMU_PWR_RST[SPMU_PWR_DOUBLE],
    err_sel:     SPMU_PWR_RST[SPMU_PWR_ERRSEL],
    tx_src:      SPMU_SRC_RST[SPMU_SRC_TX],
    rx_src:      SPMU_SRC_RST[SPMU_SRC_RX],
    rx_st:       SPMU_RX_IDLE,
    rx_prev:     1'b1,
    m0_clk:      1'b1,
    txd:         1'b1,
    rxd_o:       1'b1,
    default:     '0
  };

  spmu_top_s q;
  spmu_top_s d;

  logic tx_line;
  logic tx_done;

  spmu_tick_if tick_bus ();

  // ----------------------------------------------------------------
  // Baud ticks and transmit shifter
  // ----------------------------------------------------------------
  spmu_baud_gen u_baud (
    .sys_clk_in     (sys_clk_in),
    .srst_in        (srst_in),
    .ce_in          (ce_in),
    .mode_in        (q.mode),
    .baud_double_in (q.baud_double),
    .tx_src_sel_in  (q.tx_src),
    .rx_src_sel_in  (q.rx_src),
    .timer1_ovf_in  (timer1_ovf_in),
    .timer2_ovf_in  (timer2_ovf_in),
    .tick           (tick_bus.src)
  );

  spmu_async_tx u_tx (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .start_in    (q.tx_start),
    .data_in     (q.tx_data),
    .ninth_en_in (q.mode[1]),
    .ninth_in    (q.tx_ninth),
    .tick        (tick_bus.sink),
    .txd_out     (tx_line),
    .done_out    (tx_done)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       req;
    logic       wr_ack;
    logic       buf_wr;
    logic       fall;
    logic       stop_bit;
    logic [7:0] rx_byte;
    logic       rx_ninth;
    logic [7:0] bcast;
    logic       match;
    logic       accept;
    req      = avs_read_in | avs_write_in;
    wr_ack   = 1'b0;
    buf_wr   = 1'b0;
    fall     = 1'b0;
    stop_bit = 1'b0;
    rx_byte  = 8'h00;
    rx_ninth = 1'b0;
    bcast    = 8'h00;
    match    = 1'b0;
    accept   = 1'b0;
    d = q;
    d.tx_start = 1'b0;

    // Bus: the request is seen with waitrequest high, answered one cycle later.
    if (q.wait_req) begin
      if (req) begin
        d.wait_req = 1'b0;
        case (avs_address_in)
          SPMU_OFF_CTRL: d.rdata = {q.err_sel ? q.fe : q.mode[1], q.mode[0],
                                    q.filter_en, q.rx_en, q.tb8, q.rb8, q.ti, q.ri};
          SPMU_OFF_BUF:  d.rdata = q.rx_buf;
          SPMU_OFF_ADDR: d.rdata = q.node_addr;
          SPMU_OFF_MASK: d.rdata = q.node_mask;
          SPMU_OFF_PWR:  d.rdata = {q.baud_double, q.err_sel, 6'h00};
          SPMU_OFF_SRC:  d.rdata = {6'h00, q.rx_src, q.tx_src};
          default:       d.rdata = 8'h00;
        endcase
      end
    end else begin
      d.wait_req = 1'b1;
      wr_ack     = avs_write_in;
    end

    if (wr_ack) begin
      case (avs_address_in)
        SPMU_OFF_CTRL: begin
          if (q.err_sel) begin
            d.fe   = avs_writedata_in[SPMU_CTRL_MODE_HI];
            d.mode = spmu_mode_e'({q.mode[1], avs_writedata_in[SPMU_CTRL_MODE_LO]});
          end else begin
            d.mode = spmu_mode_e'(avs_writedata_in[SPMU_CTRL_MODE_HI:SPMU_CTRL_MODE_LO]);
          end
          d.filter_en = avs_writedata_in[SPMU_CTRL_FILTER];
          d.rx_en     = avs_writedata_in[SPMU_CTRL_RX_EN];
          d.tb8       = avs_writedata_in[SPMU_CTRL_TB8];
          d.rb8       = avs_writedata_in[SPMU_CTRL_RB8];
          d.ti        = avs_writedata_in[SPMU_CTRL_TI];
          d.ri        = avs_writedata_in[SPMU_CTRL_RI];
        end
        SPMU_OFF_BUF:  buf_wr = 1'b1;
        SPMU_OFF_ADDR: d.node_addr = avs_writedata_in[7:0];
        SPMU_OFF_MASK: d.node_mask = avs_writedata_in[7:0];
        SPMU_OFF_PWR: begin
          d.baud_double = avs_writedata_in[SPMU_PWR_DOUBLE];
          d.err_sel     = avs_writedata_in[SPMU_PWR_ERRSEL];
        end
        SPMU_OFF_SRC: begin
          d.tx_src = avs_writedata_in[SPMU_SRC_TX];
          d.rx_src = avs_writedata_in[SPMU_SRC_RX];
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Transmit start
    // ----------------------------------------------------------------
    if (buf_wr) begin
      if (q.mode == SPMU_MODE0) begin
        if (!q.m0_act) begin
          d.m0_act   = 1'b1;
          d.m0_rx    = 1'b0;
          d.m0_fell  = 1'b0;
          d.m0_cnt   = 4'h0;
          d.m0_shift = avs_writedata_in[7:0];
          d.rxd_oe   = 1'b1;
        end
      end else begin
        d.tx_start = 1'b1;
        d.tx_data  = avs_writedata_in[7:0];
        d.tx_ninth = q.tb8;
      end
    end
    if (tx_done) begin
      d.ti = 1'b1;
    end

    // ----------------------------------------------------------------
    // Mode 0 shift engine, shared by both directions of the data pin
    // ----------------------------------------------------------------
    if (q.mode == SPMU_MODE0 && !q.m0_act && !buf_wr && q.rx_en && !q.ri) begin
      d.m0_act  = 1'b1;
      d.m0_rx   = 1'b1;
      d.m0_fell = 1'b0;
      d.m0_cnt  = 4'h0;
      d.rxd_oe  = 1'b0;
    end
    if (q.m0_act) begin
      if (tick_bus.m0_fall) begin
        d.m0_fell = 1'b1;
        d.m0_clk  = 1'b0;
        if (!q.m0_rx) begin
          d.rxd_o = q.m0_shift[0];
        end
      end
      if (tick_bus.m0_rise && q.m0_fell) begin
        d.m0_clk   = 1'b1;
        d.m0_cnt   = q.m0_cnt + 4'h1;
        d.m0_shift = {q.m0_rx ? rxd_in : 1'b1, q.m0_shift[7:1]};
        if (q.m0_cnt == SPMU_BITS_M0) begin
          d.m0_act = 1'b0;
          d.rxd_oe = 1'b0;
          d.rxd_o  = 1'b1;
          if (q.m0_rx) begin
            d.rx_buf = {rxd_in, q.m0_shift[7:1]};
            d.ri     = 1'b1;
          end else begin
            d.ti = 1'b1;
          end
        end
      end
    end
    if (q.mode != SPMU_MODE0) begin
      d.m0_act = 1'b0;
      d.m0_clk = 1'b1;
      d.rxd_oe = 1'b0;
    end

    // ----------------------------------------------------------------
    // Asynchronous receiver, independent of the transmitter
    // ----------------------------------------------------------------
    fall      = q.rx_prev & ~rxd_in;
    d.rx_prev = rxd_in;
    stop_bit  = rxd_in;
    rx_byte   = (q.mode == SPMU_MODE1) ? q.rx_shift[8:1] : q.rx_shift[7:0];
    rx_ninth  = (q.mode == SPMU_MODE1) ? stop_bit : q.rx_shift[8];
    bcast     = q.node_addr | q.node_mask;
    match     = (((rx_byte ^ q.node_addr) & q.node_mask) == 8'h00)
              || ((rx_byte & bcast) == bcast);
    case (q.rx_st)
      SPMU_RX_IDLE: begin
        if (fall && q.rx_en && q.mode != SPMU_MODE0) begin
          d.rx_st  = SPMU_RX_START;
          d.rx_sub = 4'h0;
        end
      end
      SPMU_RX_START: begin
        if (tick_bus.rx_tick) begin
          d.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == SPMU_MID_TICK) begin
            d.rx_st   = rxd_in ? SPMU_RX_IDLE : SPMU_RX_DATA;
            d.rx_sub  = 4'h0;
            d.rx_bitn = 4'h0;
          end
        end
      end
      SPMU_RX_DATA: begin
        if (tick_bus.rx_tick) begin
          d.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == SPMU_OVS_LAST) begin
            d.rx_shift = {rxd_in, q.rx_shift[8:1]};
            d.rx_bitn  = q.rx_bitn + 4'h1;
            if (q.rx_bitn == ((q.mode == SPMU_MODE1) ? 4'h7 : 4'h8)) begin
              d.rx_st = SPMU_RX_STOP;
            end
          end
        end
      end
      SPMU_RX_STOP: begin
        if (tick_bus.rx_tick) begin
          d.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == SPMU_OVS_LAST) begin
            d.rx_st = SPMU_RX_IDLE;
            if (!stop_bit) begin
              d.fe = 1'b1;
            end
            if (q.mode == SPMU_MODE1) begin
              accept = !q.filter_en || (stop_bit && match);
            end else begin
              accept = !q.filter_en || (rx_ninth && match);
            end
            if (accept) begin
              d.rx_buf = rx_byte;
              d.rb8    = rx_ninth;
              d.ri     = 1'b1;
            end
          end
        end
      end
      default: d.rx_st = SPMU_RX_IDLE;
    endcase
    if (q.mode == SPMU_MODE0) begin
      d.rx_st = SPMU_RX_IDLE;
    end

    // ----------------------------------------------------------------
    // Pin and interrupt registers
    // ----------------------------------------------------------------
    d.txd = (q.mode == SPMU_MODE0) ? d.m0_clk : tx_line;
    d.irq = d.ti | d.ri;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q <= TOP_RST;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata_out    = {24'h00_0000, q.rdata};
  assign avs_waitrequest_out = q.wait_req;
  assign rxd_out             = q.rxd_o;
  assign rxd_oe_out          = q.rxd_oe;
  assign txd_out             = q.txd;
  assign serial_irq_out      = q.irq;

endmodule : spmu_uart
`default_nettype wire

/* pkg/spmu_pkg.sv */
package spmu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] SPMU_OFF_CTRL = 5'h00;
  localparam logic [4:0] SPMU_OFF_BUF  = 5'h04;
  localparam logic [4:0] SPMU_OFF_ADDR = 5'h08;
  localparam logic [4:0] SPMU_OFF_MASK = 5'h0C;
  localparam logic [4:0] SPMU_OFF_PWR  = 5'h10;
  localparam logic [4:0] SPMU_OFF_SRC  = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SPMU_CTRL_MODE_HI = 7;
  localparam int unsigned SPMU_CTRL_MODE_LO = 6;
  localparam int unsigned SPMU_CTRL_FILTER  = 5;
  localparam int unsigned SPMU_CTRL_RX_EN   = 4;
  localparam int unsigned SPMU_CTRL_TB8     = 3;
  localparam int unsigned SPMU_CTRL_RB8     = 2;
  localparam int unsigned SPMU_CTRL_TI      = 1;
  localparam int unsigned SPMU_CTRL_RI      = 0;
  localparam int unsigned SPMU_PWR_DOUBLE   = 7;
  localparam int unsigned SPMU_PWR_ERRSEL   = 6;
  localparam int unsigned SPMU_SRC_TX       = 0;
  localparam int unsigned SPMU_SRC_RX       = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SPMU_CTRL_RST = 8'h00;
  localparam logic [7:0] SPMU_ADDR_RST = 8'h00;
  localparam logic [7:0] SPMU_MASK_RST = 8'h00;
  localparam logic [7:0] SPMU_PWR_RST  = 8'h00;
  localparam logic [7:0] SPMU_SRC_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [3:0] SPMU_M0_DIV    = 4'hC;
  localparam logic [3:0] SPMU_M0_RISE   = 4'h6;
  localparam logic [1:0] SPMU_M2_SLOW   = 2'h3;
  localparam logic [1:0] SPMU_M2_FAST   = 2'h1;
  localparam logic [3:0] SPMU_OVS_LAST  = 4'hF;
  localparam logic [3:0] SPMU_MID_TICK  = 4'h7;
  localparam logic [3:0] SPMU_BITS_M0   = 4'h7;

  typedef enum logic [1:0] {
    SPMU_MODE0 = 2'b00,
    SPMU_MODE1 = 2'b01,
    SPMU_MODE2 = 2'b10,
    SPMU_MODE3 = 2'b11
  } spmu_mode_e;

  typedef enum logic [1:0] {
    SPMU_RX_IDLE  = 2'b00,
    SPMU_RX_START = 2'b01,
    SPMU_RX_DATA  = 2'b10,
    SPMU_RX_STOP  = 2'b11
  } spmu_rx_state_e;

  typedef enum logic [0:0] {
    SPMU_TX_IDLE  = 1'b0,
    SPMU_TX_SHIFT = 1'b1
  } spmu_tx_state_e;

endpackage : spmu_pkg

/* pkg/spmu_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spmu_tick_if;
  logic m0_fall;
  logic m0_rise;
  logic tx_tick;
  logic rx_tick;
  modport src  (output m0_fall, m0_rise, tx_tick, rx_tick);
  modport sink (input  m0_fall, m0_rise, tx_tick, rx_tick);
endinterface : spmu_tick_if
`default_nettype wire

/* src/spmu_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module spmu_baud_gen
  import spmu_pkg::*;
(
  // Clock and control
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  // Configuration
  input  wire logic [1:0] mode_in,
  input  wire logic       baud_double_in,
  input  wire logic       tx_src_sel_in,
  input  wire logic       rx_src_sel_in,
  // Timer overflows
  input  wire logic       timer1_ovf_in,
  input  wire logic       timer2_ovf_in,
  // Ticks
  spmu_tick_if.src        tick
);

  typedef struct packed {
    logic [3:0] m0_cnt;
    logic [1:0] m2_cnt;
    logic       m0_fall;
    logic       m0_rise;
    logic       tx_tick;
    logic       rx_tick;
  } spmu_bg_s;

  spmu_bg_s q;
  spmu_bg_s d;

  always_comb begin
    logic m2_wrap;
    logic tx_ovf;
    logic rx_ovf;
    m2_wrap = 1'b0;
    tx_ovf  = 1'b0;
    rx_ovf  = 1'b0;
    d = q;
    d.m0_fall = (q.m0_cnt == SPMU_M0_DIV - 4'h1);
    d.m0_rise = (q.m0_cnt == SPMU_M0_RISE - 4'h1);
    d.m0_cnt  = d.m0_fall ? 4'h0 : q.m0_cnt + 4'h1;
    m2_wrap   = (q.m2_cnt == (baud_double_in ? SPMU_M2_FAST : SPMU_M2_SLOW));
    d.m2_cnt  = m2_wrap ? 2'h0 : q.m2_cnt + 2'h1;
    tx_ovf    = tx_src_sel_in ? timer2_ovf_in : timer1_ovf_in;
    rx_ovf    = rx_src_sel_in ? timer2_ovf_in : timer1_ovf_in;
    case (mode_in)
      SPMU_MODE2: begin
        d.tx_tick = m2_wrap;
        d.rx_tick = m2_wrap;
      end
      SPMU_MODE1, SPMU_MODE3: begin
        d.tx_tick = tx_ovf;
        d.rx_tick = rx_ovf;
      end
      default: begin
        d.tx_tick = 1'b0;
        d.rx_tick = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign tick.m0_fall = q.m0_fall;
  assign tick.m0_rise = q.m0_rise;
  assign tick.tx_tick = q.tx_tick;
  assign tick.rx_tick = q.rx_tick;

endmodule : spmu_baud_gen
`default_nettype wire

/* src/spmu_async_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module spmu_async_tx
  import spmu_pkg::*;
(
  // Clock and control
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  // Frame request
  input  wire logic       start_in,
  input  wire logic [7:0] data_in,
  input  wire logic       ninth_en_in,
  input  wire logic       ninth_in,
  // Ticks
  spmu_tick_if.sink       tick,
  // Line and status
  output logic            txd_out,
  output logic            done_out
);

  typedef struct packed {
    spmu_tx_state_e st;
    logic [3:0]     sub;
    logic [3:0]     bitn;
    logic [3:0]     last;
    logic [10:0]    shift;
    logic           txd;
    logic           done;
  } spmu_tx_s;

  localparam spmu_tx_s TX_RST = '{st: SPMU_TX_IDLE, txd: 1'b1, default: '0};

  spmu_tx_s q;
  spmu_tx_s d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      SPMU_TX_IDLE: begin
        d.txd = 1'b1;
        if (start_in) begin
          d.st    = SPMU_TX_SHIFT;
          d.sub   = 4'h0;
          d.bitn  = 4'h0;
          d.last  = ninth_en_in ? 4'hA : 4'h9;
          d.shift = {1'b1, ninth_en_in ? ninth_in : 1'b1, data_in, 1'b0};
          d.txd   = 1'b0;
        end
      end
      SPMU_TX_SHIFT: begin
        if (tick.tx_tick) begin
          d.sub = q.sub + 4'h1;
          if (q.sub == SPMU_OVS_LAST) begin
            d.shift = {1'b1, q.shift[10:1]};
            d.bitn  = q.bitn + 4'h1;
            d.txd   = q.shift[1];
            if (q.bitn == q.last) begin
              d.st   = SPMU_TX_IDLE;
              d.txd  = 1'b1;
              d.done = 1'b1;
            end
          end
        end
      end
      default: d = TX_RST;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q <= TX_RST;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign txd_out  = q.txd;
  assign done_out = q.done;

endmodule : spmu_async_tx
`default_nettype wire

/* dv/spmu_uart_props.sv */
`timescale 1ns/1ps
`default_nettype none
module spmu_uart_props (
  // Clock and bus
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // Pins
  input wire logic        rxd_oe_out,
  input wire logic        txd_out,
  input wire logic        serial_irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  wire req = avs_read_in || avs_write_in;
  AST_ANSWER: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  AST_ONE_WAIT: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  AST_IDLE_WAIT: assert property (!req |=> avs_waitrequest_out)
    else $error("waitrequest low while idle");
  AST_RD_UPPER: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  AST_RD_HOLD: assert property (!(req && avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data moved");
  AST_IRQ_HOLD: assert property (serial_irq_out && !(avs_write_in && !avs_waitrequest_out) |=> serial_irq_out)
    else $error("interrupt dropped without write");
  AST_RESET: assert property (disable iff (1'b0) srst_in |=> avs_waitrequest_out && txd_out && !serial_irq_out)
    else $error("bad reset state");
  AST_M0_LOW: assert property ($fell(txd_out) && rxd_oe_out |-> !txd_out [*6] ##1 txd_out)
    else $error("shift clock low phase wrong");
  AST_M0_HIGH: assert property ($rose(txd_out) && rxd_oe_out |-> txd_out [*6])
    else $error("shift clock high phase wrong");
  COV_M0: cover property ($fell(txd_out) && rxd_oe_out);
  COV_IRQ: cover property ($rose(serial_irq_out));
  COV_RD: cover property (avs_read_in && !avs_waitrequest_out);
endmodule : spmu_uart_props
bind spmu_uart spmu_uart_props spmu_uart_props_inst (.sys_clk_in, .srst_in, .avs_read_in,
  .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .rxd_oe_out, .txd_out, .serial_irq_out);
`default_nettype wire

/* dv/spmu_remote_node.sv */
`timescale 1ns/1ps
`default_nettype none
module spmu_remote_node (
  // Request
  input  wire logic        sys_clk_in,
  input  wire logic        go_in,
  input  wire logic [10:0] bits_in,
  input  wire logic [3:0]  nbits_in,
  input  wire logic [7:0]  period_in,
  // Line
  output logic             line_out,
  output logic             busy_out
);
  logic [10:0] sh_q;
  logic [3:0]  n_q;
  logic [7:0]  c_q;
  initial busy_out = 1'b0;
  // The line idles high, so every frame opens with a falling edge.
  assign line_out = busy_out ? sh_q[0] : 1'b1;
  always @(posedge sys_clk_in) begin
    c_q <= (c_q == 8'h00) ? period_in - 8'h01 : c_q - 8'h01;
    if (go_in && !busy_out) begin
      {busy_out, sh_q, n_q, c_q} <= {1'b1, bits_in, nbits_in, period_in - 8'h01};
    end else if (busy_out && c_q == 8'h00) begin
      busy_out <= (n_q != 4'h1);
      sh_q     <= sh_q >> 1;
      n_q      <= n_q - 4'h1;
    end
  end
endmodule : spmu_remote_node
`default_nettype wire

/* dv/test_spmu_uart.sv */
`timescale 1ns/1ps
`default_nettype none
module test_spmu_uart;
  import spmu_pkg::*;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, t1 = 0, t2 = 0, go = 0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic [10:0] fr = 11'h7FF;
  logic [7:0]  per = 8'h20, q;
  logic [3:0]  nb = 4'hA;
  logic        wq, rxo, oe, txd, irq, line, busy;
  int          bad_count = 0, cmp_count = 0;
  wire         pin = oe ? rxo : line;
  always #20 clk = !clk;
  always @(posedge clk) t1 <= !t1;
  always @(posedge clk) t2 <= t1;
  spmu_uart spmu_uart_inst (.sys_clk_in(clk), .srst_in(rst), .ce_in(1'b1), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .timer1_ovf_in(t1), .timer2_ovf_in(t2), .rxd_in(pin),
    .rxd_out(rxo), .rxd_oe_out(oe), .txd_out(txd), .serial_irq_out(irq));
  spmu_remote_node spmu_remote_node_inst (.sys_clk_in(clk), .go_in(go), .bits_in(fr),
    .nbits_in(nb), .period_in(per), .line_out(line), .busy_out(busy));
  task automatic end_sim();
    $display("compares %0d, wrong %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic hold(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (s !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      end_sim();
    end
  endtask : hold
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    {adr, wd, rd, wr} <= {a, 24'h00_0000, d, !w, w};
    @(posedge clk);
    hold(wq, 1'b0, 20);
    @(posedge clk);
    q = rdat[7:0];
    {rd, wr} <= 2'b00;
  endtask : bus
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rdc
  task automatic send(input logic [10:0] f, input logic [3:0] n, input logic [7:0] p);
    @(posedge clk);
    {fr, nb, per, go} <= {f, n, p, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    hold(busy, 1'b0, 2000);
    repeat (8) @(posedge clk);
  endtask : send
  task automatic t_regs();
    rdc(SPMU_OFF_CTRL, SPMU_CTRL_RST);
    rdc(SPMU_OFF_MASK, SPMU_MASK_RST);
    bus(1'b1, SPMU_OFF_ADDR, 8'h5A);
    rdc(SPMU_OFF_ADDR, 8'h5A);
    rdc(5'h18, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_m1_tx();
    logic [9:0] f;
    f = {1'b1, 8'hA5, 1'b0};
    bus(1'b1, SPMU_OFF_CTRL, 8'h40);
    bus(1'b1, SPMU_OFF_BUF, 8'hA5);
    hold(txd, 1'b0, 200);
    repeat (16) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      chk({7'h00, txd}, {7'h00, f[i]});
      repeat (32) @(posedge clk);
    end
    rdc(SPMU_OFF_CTRL, 8'h42);
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, SPMU_OFF_CTRL, 8'h50);
    $display("test mode 1 transmit done");
  endtask : t_m1_tx
  task automatic t_m1_rx();
    bus(1'b1, SPMU_OFF_BUF, 8'h0F);
    send({2'b11, 8'h3C, 1'b0}, 4'hA, 8'h20);
    rdc(SPMU_OFF_BUF, 8'h3C);
    rdc(SPMU_OFF_CTRL, 8'h57);
    $display("test mode 1 receive done");
  endtask : t_m1_rx
  task automatic t_m2();
    bus(1'b1, SPMU_OFF_ADDR, 8'hC0);
    bus(1'b1, SPMU_OFF_MASK, 8'hFD);
    bus(1'b1, SPMU_OFF_CTRL, 8'hB0);
    send({2'b11, 8'hC4, 1'b0}, 4'hB, 8'h40);
    rdc(SPMU_OFF_CTRL, 8'hB0);
    rdc(SPMU_OFF_BUF, 8'h3C);
    send({2'b11, 8'hC2, 1'b0}, 4'hB, 8'h40);
    rdc(SPMU_OFF_BUF, 8'hC2);
    rdc(SPMU_OFF_CTRL, 8'hB5);
    $display("test mode 2 filter done");
  endtask : t_m2
  task automatic t_m0();
    logic [7:0] b;
    b = 8'h96;
    bus(1'b1, SPMU_OFF_CTRL, 8'h00);
    bus(1'b1, SPMU_OFF_BUF, b);
    for (int i = 0; i < 8; i++) begin
      hold(txd, 1'b0, 40);
      chk({6'h00, oe, rxo}, {6'h00, 1'b1, b[i]});
      hold(txd, 1'b1, 40);
    end
    repeat (4) @(posedge clk);
    rdc(SPMU_OFF_CTRL, 8'h02);
    bus(1'b1, SPMU_OFF_CTRL, 8'h10);
    repeat (120) @(posedge clk);
    rdc(SPMU_OFF_CTRL, 8'h11);
    rdc(SPMU_OFF_BUF, 8'hFF);
    $display("test mode 0 transmit done");
  endtask : t_m0
  task automatic t_fe();
    bus(1'b1, SPMU_OFF_CTRL, 8'hD0);
    bus(1'b1, SPMU_OFF_SRC, 8'h03);
    bus(1'b1, SPMU_OFF_PWR, 8'h40);
    send({2'b00, 8'h55, 1'b0}, 4'hB, 8'h20);
    rdc(SPMU_OFF_BUF, 8'h55);
    send({2'b11, 8'hAA, 1'b0}, 4'hB, 8'h20);
    rdc(SPMU_OFF_CTRL, 8'hD5);
    bus(1'b1, SPMU_OFF_CTRL, 8'h50);
    rdc(SPMU_OFF_CTRL, 8'h50);
    bus(1'b1, SPMU_OFF_PWR, 8'h00);
    rdc(SPMU_OFF_CTRL, 8'hD0);
    $display("test framing error done");
  endtask : t_fe
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_m1_tx();
    t_m1_rx();
    t_m2();
    t_m0();
    t_fe();
    end_sim();
  end
endmodule : test_spmu_uart
`default_nettype wire
